/* logic/pes_shutdown.v */
// Purpose: emergency shutdown control of a six-channel PWM unit
// Assumes: classic Wishbone slave, registers one per aligned word
// Notes:   forced level applied while shutdown active; restart waits for wrap
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps
`include "pes_regs.vh"
module pes_shutdown (
  input  wire                  clk_i,
  input  wire                  rst_i,
  input  wire                  wb_cyc_i,
  input  wire                  wb_stb_i,
  input  wire                  wb_we_i,
  input  wire [`PES_ADDR_W-1:0] wb_adr_i,
  input  wire [3:0]            wb_sel_i,
  input  wire [31:0]           wb_dat_i,
  output reg  [31:0]           wb_dat_o,
  output reg                   wb_ack_o,
  output reg                   wb_err_o,
  input  wire                  shutdown_pin_i,
  input  wire [`PES_NCH-1:0]   pwm_i,
  input  wire [`PES_NCH-1:0]   cnt_zero_i,
  output wire [`PES_NCH-1:0]   pwm_o,
  output reg                   irq_o,
  output reg                   shutdown_irq_o
);
  reg        flag_q;
  reg        irq_en_q;
  reg        level_q;
  reg        polarity_q;
  reg        func_en_q;
  reg        hold_q;
  reg [`PES_NCH-1:0]   chan_en_q;
  reg [`PES_EV_W-1:0]  stat_q;
  reg [`PES_EV_W-1:0]  mask_q;
  reg [31:0] rd_d;
  wire       pin_q;
  wire       active;
  wire       rise;
  wire       fall;
  wire       req;
  wire       wr;
  wire       rd;
  wire [3:0] idx;
  wire       hit;
  wire       wr_sdn;
  wire       restart_ok;
  wire       func_off;
  wire [`PES_NCH-1:0] running;
  wire [7:0] sdn_rd;

  pes_edge_detect u_edge (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (shutdown_pin_i),
    .polarity_i (polarity_q),
    .pin_q      (pin_q),
    .active_o   (active),
    .rise_o     (rise),
    .fall_o     (fall)
  );

  // bus decode, one-cycle ack after request, drop next cycle
  assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign idx  = wb_adr_i[5:2];
  assign hit  = (wb_adr_i[1:0] == 2'b00) &&
                (idx == `PES_IDX_SDN || idx == `PES_IDX_IRQ_STAT ||
                 idx == `PES_IDX_IRQ_MASK || idx == `PES_IDX_CHAN_EN);
  assign wr   = req & hit & wb_we_i;
  assign rd   = req & hit & ~wb_we_i;
  assign wr_sdn = wr & (idx == `PES_IDX_SDN) & wb_sel_i[0];

  assign restart_ok = wr_sdn & wb_dat_i[`PES_BIT_RESTART] & ~active;
  assign func_off   = wr_sdn & func_en_q & ~wb_dat_i[`PES_BIT_FUNC_EN];

  // restart bit and bit 3 read zero
  assign sdn_rd = {flag_q, irq_en_q, 1'b0, level_q, 1'b0,
                   pin_q, polarity_q, func_en_q};

  always @* begin
    rd_d = 32'h00000000;
    case (idx)
      `PES_IDX_SDN:      rd_d = {24'h000000, sdn_rd};
      `PES_IDX_IRQ_STAT: rd_d = {29'h00000000, stat_q};
      `PES_IDX_IRQ_MASK: rd_d = {29'h00000000, mask_q};
      `PES_IDX_CHAN_EN:  rd_d = {26'h0000000, chan_en_q};
      default:           rd_d = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      wb_dat_o <= rd ? rd_d : 32'h00000000;
    end
  end

  // shutdown register fields, channel enable and interrupt mask
  always @(posedge clk_i) begin
    if (rst_i) begin
      flag_q     <= 1'b0;
      irq_en_q   <= 1'b0;
      level_q    <= 1'b0;
      polarity_q <= 1'b0;
      func_en_q  <= 1'b0;
      chan_en_q  <= {`PES_NCH{1'b0}};
      mask_q     <= {`PES_EV_W{1'b0}};
    end else begin
      if (func_en_q && (rise || fall))
        flag_q <= 1'b1;
      else if (wr_sdn && wb_dat_i[`PES_BIT_FLAG])
        flag_q <= 1'b0;
      if (wr_sdn) begin
        irq_en_q   <= wb_dat_i[`PES_BIT_IRQ_EN];
        level_q    <= wb_dat_i[`PES_BIT_LEVEL];
        polarity_q <= wb_dat_i[`PES_BIT_POLARITY];
        func_en_q  <= wb_dat_i[`PES_BIT_FUNC_EN];
      end
      if (wr && idx == `PES_IDX_CHAN_EN && wb_sel_i[0])
        chan_en_q <= wb_dat_i[`PES_NCH-1:0];
      if (wr && idx == `PES_IDX_IRQ_MASK && wb_sel_i[0])
        mask_q <= wb_dat_i[`PES_EV_W-1:0];
    end
  end

  // hold channels after shutdown until restart or disable
  always @(posedge clk_i) begin
    if (rst_i)
      hold_q <= 1'b0;
    else if (func_en_q && active)
      hold_q <= 1'b1;
    else if (restart_ok || func_off)
      hold_q <= 1'b0;
  end

  // sticky status, cleared on read, set wins
  always @(posedge clk_i) begin
    if (rst_i)
      stat_q <= {`PES_EV_W{1'b0}};
    else
      stat_q <= (rd && idx == `PES_IDX_IRQ_STAT ? {`PES_EV_W{1'b0}} : stat_q) |
                {restart_ok, func_en_q & fall, func_en_q & rise};
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o          <= 1'b0;
      shutdown_irq_o <= 1'b0;
    end else begin
      irq_o          <= |(stat_q & mask_q);
      shutdown_irq_o <= irq_en_q & flag_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `PES_NCH; g = g + 1) begin : g_ch
      pes_channel_gate u_gate (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .chan_en_i  (chan_en_q[g]),
        .pwm_i      (pwm_i[g]),
        .cnt_zero_i (cnt_zero_i[g]),
        .force_i    (func_en_q & active),
        .level_i    (level_q),
        .hold_i     (hold_q),
        .pwm_o      (pwm_o[g]),
        .running_o  (running[g])
      );
    end
  endgenerate
endmodule

/* pkg/pes_regs.vh */
// Purpose: register offsets, fields and reset values of the PWM shutdown unit
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes:   shutdown register index is 0x0E, byte address four times that
`ifndef PES_REGS_VH
`define PES_REGS_VH

`define PES_IDX_SDN        4'hE
`define PES_IDX_IRQ_STAT   4'hF
`define PES_IDX_IRQ_MASK   4'hD
`define PES_IDX_CHAN_EN    4'hC
`define PES_ADDR_W         6
`define PES_NCH            6

`define PES_BIT_FLAG       7
`define PES_BIT_IRQ_EN     6
`define PES_BIT_RESTART    5
`define PES_BIT_LEVEL      4
`define PES_BIT_IN_STATE   2
`define PES_BIT_POLARITY   1
`define PES_BIT_FUNC_EN    0

`define PES_SDN_RESET      8'h00
`define PES_SDN_WMASK      8'hD3

`define PES_EV_ASSERT      0
`define PES_EV_RELEASE     1
`define PES_EV_RESTART     2
`define PES_EV_W           3

`endif

/* logic/pes_edge_detect.v */
// Purpose: registers the shutdown pin and reports active state and changes
// Assumes: pin synchronous to clk_i
// Notes:   polarity selects which level counts as active
`timescale 1ns/100ps
module pes_edge_detect (
  input  wire clk_i,
  input  wire rst_i,
  input  wire pin_i,
  input  wire polarity_i,
  output reg  pin_q,
  output wire active_o,
  output wire rise_o,
  output wire fall_o
);
  reg prev_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_q  <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      pin_q  <= pin_i;
      prev_q <= pin_q;
    end
  end

  // level chosen by polarity counts as active
  assign active_o = ~(pin_q ^ polarity_i);
  // only a real pin change counts, a polarity write gives no edge
  assign rise_o   = (pin_q ^ prev_q) & active_o;
  assign fall_o   = (pin_q ^ prev_q) & ~active_o;
endmodule

/* logic/pes_channel_gate.v */
// Purpose: per-channel hold-off until counter wrap, and forced output level
// Assumes: counter-zero indication is one cycle per wrap
// Notes:   output comes from a flip-flop
`timescale 1ns/100ps
module pes_channel_gate (
  input  wire clk_i,
  input  wire rst_i,
  input  wire chan_en_i,
  input  wire pwm_i,
  input  wire cnt_zero_i,
  input  wire force_i,
  input  wire level_i,
  input  wire hold_i,
  output reg  pwm_o,
  output reg  running_o
);
  always @(posedge clk_i) begin
    if (rst_i) begin
      running_o <= 1'b1;
      pwm_o     <= 1'b0;
    end else begin
      if (hold_i)
        running_o <= 1'b0;
      else if (cnt_zero_i)
        running_o <= 1'b1;
      if (chan_en_i && force_i)
        pwm_o <= level_i;
      else if (chan_en_i && running_o && !hold_i)
        pwm_o <= pwm_i;
      else if (chan_en_i)
        pwm_o <= level_i;
      else
        pwm_o <= pwm_i;
    end
  end
endmodule

/* tb/pes_pin_model.sv */
// Purpose: far-side driver of the shutdown pin
// Assumes: pin synchronous to clk_i
// Notes:   follows the request after lag_i cycles
`timescale 1ns/100ps
module pes_pin_model (
  input  wire logic       clk_i,
  input  wire logic       act_i,
  input  wire logic [3:0] lag_i,
  input  wire logic       pol_i,
  output logic            pin_o
);
  logic [3:0] cnt_q = 4'h0;
  initial pin_o = 1'b0;
  always @(posedge clk_i) begin
    cnt_q <= cnt_q + 4'h1;
    if ((pin_o == pol_i) == act_i)
      cnt_q <= 4'h0;
    else if (cnt_q >= lag_i)
      pin_o <= act_i ? pol_i : ~pol_i;
  end
endmodule

/* tb/pes_shutdown_sva.sv */
// Purpose: port checker for pes_shutdown
// Assumes: master holds request until ack
// Notes:   shadows config from bus writes
`timescale 1ns/100ps
module pes_shutdown_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        shutdown_pin_i,
  input wire logic [5:0]  pwm_o,
  input wire logic        shutdown_irq_o
);
  logic [7:0] sdn_q;
  logic [5:0] ce_q;
  wire wr = wb_ack_o && wb_we_i;
  always @(posedge clk_i)
    if (rst_i) begin
      sdn_q <= 8'h00;
      ce_q <= 6'h00;
    end else if (wr && wb_adr_i == 6'h38)
      sdn_q <= wb_dat_i[7:0];
    else if (wr && wb_adr_i == 6'h30)
      ce_q <= wb_dat_i[5:0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence act_s;
    (sdn_q[0] && shutdown_pin_i == sdn_q[1])[*3];
  endsequence
  chk_ack_next: assert property (req_s |=> wb_ack_o || wb_err_o) else $error("no bus answer");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_err_align: assert property (req_s ##0 wb_adr_i[1:0] != 2'h0 |=> wb_err_o) else $error("no err");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
  chk_rd_zero: assert property (wr == 1'b0 && wb_ack_o && wb_adr_i == 6'h38 |->
    wb_dat_o[5] == 1'b0 && wb_dat_o[3] == 1'b0) else $error("zero bit read as one");
  chk_irq_gate: assert property (!sdn_q[6] && !$past(sdn_q[6]) |-> !shutdown_irq_o) else $error("irq while off");
  chk_force_lvl: assert property (act_s |-> (pwm_o & ce_q) == ({6{sdn_q[4]}} & ce_q))
    else $error("output not forced");
  chk_flag_set: assert property (sdn_q[0] && sdn_q[6] && $changed(shutdown_pin_i)
    |-> ##[2:3] shutdown_irq_o) else $error("change not flagged");
endmodule
bind pes_shutdown pes_shutdown_sva pes_shutdown_sva_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .shutdown_pin_i, .pwm_o, .shutdown_irq_o);

/* tb/pes_shutdown_tb.sv */
// Purpose: self-checking bench for pes_shutdown
// Assumes: 40 MHz clock, one-cycle bus answer
// Notes:   read data checked by a queue monitor
`timescale 1ns/100ps
module pes_shutdown_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, act = 1'b0, zen = 1'b1;
  logic [5:0]  adr = 6'h00, pwm = 6'h00, cz = 6'h00, pwm_o;
  logic [3:0]  lag = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic        ack, err, pin, irq, sirq;
  logic [31:0] exp_q[$];
  int          fails = 0, total_checks = 0, ticks = 0;
  always #12.5 clk_i = ~clk_i;
  pes_shutdown pes_shutdown_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
    .shutdown_pin_i(pin), .pwm_i(pwm), .cnt_zero_i(cz), .pwm_o, .irq_o(irq), .shutdown_irq_o(sirq));
  pes_pin_model pes_pin_model_inst (.clk_i, .act_i(act), .lag_i(lag), .pol_i(1'b1), .pin_o(pin));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [5:0] a, logic [7:0] d, logic [31:0] e = 32'h0);
    if (!w)
      exp_q.push_back(e);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (!ack && !err);
    cyc <= 1'b0;
  endtask
  task automatic pin_to(logic v);
    lag <= 4'($urandom);
    act <= v;
    repeat (20) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    ticks++;
    cz <= zen ? {cz[4:0], cz[5] | ~|cz} : 6'h00;
    if (ack && !we)
      chk("read data", dat_o, exp_q.pop_front());
    if (ticks == 2000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h7a43e5d7));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, 6'h38, 8'h00, 32'h0);
    bus(1, 6'h04, 8'hFF);
    chk("err", 32'(err), 32'h1);
    bus(1, 6'h39, 8'hFF);
    chk("err", 32'(err), 32'h1);
    bus(1, 6'h30, 8'h3F);
    bus(1, 6'h34, 8'h07);
    bus(1, 6'h38, 8'h5B);
    bus(0, 6'h38, 8'h00, 32'h53);
    pwm <= 6'($urandom);
    pin_to(1'b1);
    chk("forced", 32'(pwm_o), 32'h3F);
    chk("irq", {30'h0, sirq, irq}, 32'h3);
    bus(1, 6'h38, 8'h73);
    bus(0, 6'h38, 8'h00, 32'hD7);
    bus(0, 6'h3C, 8'h00, 32'h01);
    pin_to(1'b0);
    chk("held", 32'(pwm_o), 32'h3F);
    bus(0, 6'h3C, 8'h00, 32'h02);
    bus(1, 6'h38, 8'hD3);
    bus(0, 6'h38, 8'h00, 32'h53);
    chk("irq", {30'h0, sirq, irq}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      zen <= 1'b0;
      bus(1, 6'h38, i ? 8'hD2 : 8'h73);
      repeat (10) @(posedge clk_i);
      chk("wait zero", 32'(pwm_o), 32'h3F);
      zen <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk("resumed", 32'(pwm_o), 32'(pwm));
      bus(0, 6'h3C, 8'h00, i ? 32'h03 : 32'h04);
      bus(1, 6'h34, 8'h00);
      pin_to(1'b1);
      chk("masked", {30'h0, sirq, irq}, i ? 32'h0 : 32'h2);
      chk("gated", 32'(pwm_o), i ? 32'(pwm) : 32'h3F);
      pin_to(1'b0);
    end
    wrap_up();
  end
endmodule
